//--- spi_flash_defines.svh
// constants for the flash power-down and quad read mode block
`ifndef SPI_FLASH_DEFINES_SVH
`define SPI_FLASH_DEFINES_SVH

// ****************************************************************
// opcodes and mode byte values
// ****************************************************************
`define OP_PWRDN       8'hB9
`define OP_WAKE        8'hAB
`define OP_RD_SR1      8'h05
`define OP_RD_SR2      8'h35
`define OP_WR_SR       8'h01
`define OP_RD_PARAM    8'h5A
`define OP_QUAD_READ   8'hEB
`define MODE_ENTER     8'hA5
`define MODE_EXIT      8'h00
`define MODE_RESET     8'hFF
`define ADDR_ALL_ONES  24'hFFFFFF

// ****************************************************************
// status bit positions
// ****************************************************************
`define SR1_BUSY_BIT   0
`define SR2_QE_BIT     1

// ****************************************************************
// parameter words
// ****************************************************************
`define PARAM_W14_ADDR 24'h000034
`define PARAM_SPAN     24'h000008
`define PARAM_W14      32'h5CD5A2F7
`define PARAM_W15      32'hFF59F600
`define PARAM_BLANK    8'hFF

// ****************************************************************
// phase lengths in link clocks, last count
// ****************************************************************
`define LAST_BYTE_1    5'h07
`define LAST_BYTE_4    5'h01
`define LAST_ADDR_1    5'h17
`define LAST_ADDR_4    5'h05
`define LAST_DUMMY_1   5'h07
`define LAST_DUMMY_4   5'h03
`define LAST_WRSR      5'h0F

// ****************************************************************
// wake recovery time
// ****************************************************************
`define WAKE_TIME_US   3
`define SYS_PERIOD_NS  40
`define WAKE_CYC  ((`WAKE_TIME_US * 1000 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

// ****************************************************************
// register map
// ****************************************************************
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define CTRL_BUSY_BIT  0
`define STAT_BUSY_BIT  0
`define STAT_QE_BIT    1
`define STAT_PD_BIT    2
`define STAT_CONT_BIT  3

`endif

//--- spi_flash_pkg.sv
// types for the flash power-down and quad read mode block
package spi_flash_pkg;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_WRSR,
        ST_IGNORE
    } link_state_e;

    // per-frame state, cleared while chip select is high
    typedef struct packed {
        link_state_e state;
        logic        wide;
        logic [4:0]  cnt;
        logic [23:0] sh;
        logic [23:0] addr;
        logic [7:0]  op;
        logic [7:0]  tx;
        logic [3:0]  dq_o;
        logic [3:0]  dq_oe;
    } frame_s;

    // state kept across frames
    typedef struct packed {
        logic       qe;
        logic       pd;
        logic       cont;
        logic       wake_tgl;
        logic [2:0] bsync;
        logic       write_in_progress_flag;
    } keep_s;

    // system clock side
    typedef struct packed {
        logic        ctrl_busy;
        logic [7:0]  wake_cnt;
        logic        busy;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  sync3;
        logic [3:0]  flt;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sys_s;

endpackage

//--- spi_flash_pwrdn_quad_mode.sv
// flash command slice: power-down, busy polling, quad enable, quad read
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "spi_flash_defines.svh"

//
// Overview of operation
// (R1) Opcode B9h puts the device into deep power-down.
// (R2) Opcode ABh takes the device out of deep power-down.
// (R3) After waking, the device is busy for at most 3 us, (2+1) x 1 us.
// (R4) Status register 1 via 05h shows bit 0 as 1 while busy, 0 when ready.
// (R5) Quad enable sits in bit 1 of status register 2, read with 35h.
// (R6) Write status 01h with two bytes sets quad enable from bit 1 of byte 2.
// (R7) Hold and write-protect inputs keep their function in every mode.
// (R8) Mode byte A5h after the address enters continuous quad read mode.
// (R9) Mode byte 00h leaves continuous mode after the current read.
// (R10) All ones on the four lines for eight clocks resets the mode bits.
// (R11) No all-quad command mode; its enable and disable fields read zero.
// (R12) Parameter word 14 reads 5C D5 A2 F7 with its reserved bits as ones.
// (R13) Parameter word 15 reads FF 59 F6 00, flagging continuous quad read.
// (R14) Bit 31 of parameter word 14 is 0, so deep power-down is supported.
// (R15) In power-down all opcodes but wake are ignored and outputs float.
module spi_flash_pwrdn_quad_mode
    import spi_flash_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              sck_i,
    input  wire logic              cs_n_i,
    input  wire logic              hold_n_i,
    input  wire logic              wp_n_i,
    input  wire logic [3:0]        dq_i,
    output logic      [3:0]        dq_o,
    output logic      [3:0]        dq_oe_o
);

    // ****************************************************************
    // decoding functions
    // ****************************************************************

    // parameter table bytes, little endian words
    function automatic logic [7:0] param_byte(input logic [23:0] a);
        logic [63:0] words;
        logic [23:0] diff;
        words = {`PARAM_W15, `PARAM_W14}; // R11 R12 R13 R14
        diff  = a - `PARAM_W14_ADDR;
        if (a >= `PARAM_W14_ADDR && diff < `PARAM_SPAN) begin
            param_byte = words[{diff[2:0], 3'h0} +: 8];
        end else begin
            param_byte = `PARAM_BLANK;
        end
    endfunction

    // status register bytes
    function automatic logic [7:0] stat_byte(input logic [7:0] op,
                                             input logic       write_in_progress_flag,
                                             input logic       qe);
        stat_byte = 8'h00;
        if (op == `OP_RD_SR1) begin
            stat_byte[`SR1_BUSY_BIT] = write_in_progress_flag; // R4
        end else begin
            stat_byte[`SR2_QE_BIT] = qe; // R5
        end
    endfunction

    function automatic logic is_status(input logic [7:0] op);
        is_status = (op == `OP_RD_SR1) || (op == `OP_RD_SR2);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    frame_s      f;
    frame_s      next_f;
    keep_s       k;
    keep_s       next_k;
    sys_s        s;
    sys_s        next_s;
    link_state_e st;
    logic        wide;
    logic [23:0] shin;
    logic [7:0]  byte_in;
    logic        frame_clr;

    assign frame_clr = cs_n_i | ~nrst_i;

    // ****************************************************************
    // link side
    // ****************************************************************
    always_comb begin
        next_f = f;
        next_k = k;
        st     = f.state;
        wide   = f.wide;
        // continuous mode frames start straight at the address
        if (f.state == ST_OPCODE && k.cont && !k.pd) begin
            st   = ST_ADDR; // R8
            wide = 1'b1;
        end
        shin    = wide ? {f.sh[19:0], dq_i} : {f.sh[22:0], dq_i[0]};
        byte_in = shin[7:0];
        // busy level from the system side
        next_k.bsync = {k.bsync[1:0], s.busy};
        if (k.bsync[2] == k.bsync[1]) begin
            next_k.write_in_progress_flag = k.bsync[2];
        end
        if (!hold_n_i) begin
            // paused: freeze the frame, release the lines
            next_f.dq_oe = 4'h0; // R7
        end else begin
            next_f.cnt = f.cnt + 5'h01;
            next_f.sh  = shin;
            unique case (st)
                ST_OPCODE: begin
                    if (f.cnt == `LAST_BYTE_1) begin
                        next_f.cnt   = 5'h00;
                        next_f.op    = byte_in;
                        next_f.state = ST_IGNORE;
                        next_f.wide  = 1'b0;
                        if (k.pd) begin
                            if (byte_in == `OP_WAKE) begin // R15
                                next_k.pd       = 1'b0; // R2
                                next_k.wake_tgl = ~k.wake_tgl; // R3
                            end
                        end else begin
                            case (byte_in)
                                `OP_PWRDN: begin
                                    next_k.pd = 1'b1; // R1
                                end
                                `OP_RD_SR1, `OP_RD_SR2: begin
                                    next_f.state = ST_DATA; // R4 R5
                                    next_f.tx    = stat_byte(byte_in,
                                                             k.write_in_progress_flag, k.qe);
                                end
                                `OP_WR_SR: begin
                                    next_f.state = ST_WRSR;
                                end
                                `OP_RD_PARAM: begin
                                    next_f.state = ST_ADDR;
                                end
                                `OP_QUAD_READ: begin
                                    if (k.qe) begin
                                        next_f.state = ST_ADDR;
                                        next_f.wide  = 1'b1;
                                    end
                                end
                                default: begin
                                    next_f.state = ST_IGNORE;
                                end
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    if (f.cnt == (wide ? `LAST_ADDR_4 : `LAST_ADDR_1)) begin
                        next_f.cnt   = 5'h00;
                        next_f.addr  = shin;
                        next_f.wide  = wide;
                        next_f.state = wide ? ST_MODE : ST_DUMMY;
                        if (wide) begin
                            next_f.op = `OP_QUAD_READ;
                        end
                    end
                end
                ST_MODE: begin
                    if (f.cnt == `LAST_BYTE_4) begin
                        next_f.cnt   = 5'h00;
                        next_f.state = ST_DUMMY;
                        if (byte_in == `MODE_ENTER) begin
                            next_k.cont = 1'b1; // R8
                        end else if (byte_in == `MODE_EXIT) begin
                            next_k.cont = 1'b0; // R9
                        end else if (byte_in == `MODE_RESET &&
                                     f.addr == `ADDR_ALL_ONES) begin
                            next_k.cont  = 1'b0; // R10
                            next_f.state = ST_IGNORE;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (f.cnt == (f.wide ? `LAST_DUMMY_4 : `LAST_DUMMY_1))
                    begin
                        next_f.cnt   = 5'h00;
                        next_f.state = ST_DATA;
                        next_f.tx    = param_byte(f.addr); // R12 R13
                        next_f.addr  = f.addr + 24'h000001;
                    end
                end
                ST_DATA: begin
                    if (f.cnt == (f.wide ? `LAST_BYTE_4 : `LAST_BYTE_1)) begin
                        next_f.cnt = 5'h00;
                        if (is_status(f.op)) begin
                            next_f.tx = stat_byte(f.op, k.write_in_progress_flag, k.qe); // R4
                        end else begin
                            next_f.tx   = param_byte(f.addr);
                            next_f.addr = f.addr + 24'h000001;
                        end
                    end else if (f.wide) begin
                        next_f.tx = {f.tx[3:0], 4'h0};
                    end else begin
                        next_f.tx = {f.tx[6:0], 1'b0};
                    end
                end
                ST_WRSR: begin
                    if (f.cnt == `LAST_WRSR) begin
                        next_f.state = ST_IGNORE;
                        if (wp_n_i) begin // R7
                            next_k.qe = shin[`SR2_QE_BIT]; // R6
                        end
                    end
                end
                ST_IGNORE: begin
                    next_f.cnt = f.cnt;
                end
            endcase
            // drive the lines from the new transmit byte
            next_f.dq_o  = 4'h0;
            next_f.dq_oe = 4'h0;
            if (next_f.state == ST_DATA && !next_k.pd) begin // R15
                if (next_f.wide) begin
                    next_f.dq_o  = next_f.tx[7:4];
                    next_f.dq_oe = 4'hF;
                end else begin
                    next_f.dq_o  = {2'h0, next_f.tx[7], 1'h0};
                    next_f.dq_oe = 4'h2;
                end
            end
        end
    end

    // frame state ends with chip select
    always_ff @(posedge sck_i or posedge frame_clr) begin
        if (frame_clr) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    always_ff @(posedge sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            k <= '0;
        end else begin
            k <= next_k;
        end
    end

    // ****************************************************************
    // system side and register bus
    // ****************************************************************
    always_comb begin
        logic [3:0] agree;
        next_s       = s;
        agree        = ~(s.sync2 ^ s.sync3);
        next_s.sync1 = {k.cont, k.pd, k.qe, k.wake_tgl};
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        next_s.flt   = (s.flt & ~agree) | (s.sync3 & agree);
        if (next_s.flt[0] != s.flt[0]) begin
            next_s.wake_cnt = 8'(`WAKE_CYC); // R3
        end else if (s.wake_cnt != 8'h00) begin
            next_s.wake_cnt = s.wake_cnt - 8'h01;
        end
        next_s.busy   = s.ctrl_busy | (next_s.wake_cnt != 8'h00); // R4
        next_s.pready = 1'b0;
        if (psel_i && penable_i && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b0;
            next_s.prdata  = 32'h00000000;
            case (paddr_i)
                `REG_CTRL: begin
                    if (pwrite_i && pstrb_i[0]) begin
                        next_s.ctrl_busy = pwdata_i[`CTRL_BUSY_BIT];
                    end
                    next_s.prdata[`CTRL_BUSY_BIT] = s.ctrl_busy;
                end
                `REG_STATUS: begin
                    next_s.prdata[`STAT_BUSY_BIT] = s.busy;
                    next_s.prdata[`STAT_QE_BIT]   = s.flt[1];
                    next_s.prdata[`STAT_PD_BIT]   = s.flt[2];
                    next_s.prdata[`STAT_CONT_BIT] = s.flt[3];
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata_o  = s.prdata;
    assign pready_o  = s.pready;
    assign pslverr_o = s.pslverr;
    assign dq_o      = f.dq_o;
    assign dq_oe_o   = f.dq_oe;

endmodule

//--- spi_flash_pwrdn_quad_mode_assertions.sv
// concurrent checks for the flash command slice
`timescale 1ns/1ns
module spi_flash_pwrdn_quad_mode_assertions
    import spi_flash_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              clk_sys_i,
    input wire logic              nrst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              sck_i,
    input wire logic              cs_n_i,
    input wire logic [3:0]        dq_oe_o
);
    // ********
    // status bus answers
    // ********
    a_ready_one_wait: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access not answered after one wait");
    a_ready_pulse: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) $rose(pready_o) |-> $past(psel_i && penable_i))
        else $error("ready without access");
    a_err_unmapped: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) pready_o |->
        pslverr_o == (paddr_i != 12'h000 && paddr_i != 12'h004))
        else $error("error flag wrong for address");
    a_err_no_data: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("data on refused access");
    a_rdata_holds: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) !pready_o |-> $stable(prdata_o))
        else $error("read data moved between answers");
    a_status_upper: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        pready_o && !pwrite_i && paddr_i == 12'h004 |-> prdata_o[31:4] == 0)
        else $error("status upper bits set");
    // ********
    // link outputs
    // ********
    a_oe_idle: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) cs_n_i |-> dq_oe_o == 4'h0)
        else $error("lines driven while deselected");
    a_oe_shape: assert property (@(posedge sck_i)
        disable iff (!nrst_i) dq_oe_o inside {4'h0, 4'h2, 4'hF})
        else $error("odd output enable pattern");
    c_refused: cover property (@(posedge clk_sys_i) pready_o && pslverr_o);
    c_quad_out: cover property (@(posedge sck_i) dq_oe_o == 4'hF);
    c_pd_seen: cover property (@(posedge clk_sys_i)
        pready_o && paddr_i == 12'h004 && prdata_o[2]);
endmodule

bind spi_flash_pwrdn_quad_mode spi_flash_pwrdn_quad_mode_assertions #(
    .ADDR_W(ADDR_W)
) chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .dq_oe_o(dq_oe_o)
);

//--- spi_host_model.sv
// spi host model driving the flash link
`timescale 1ns/1ns
module spi_host_model (
    output logic            sck_o,
    output logic            cs_n_o,
    output logic [3:0]      line_o,
    input  wire logic [3:0] dq_i,
    input  wire logic [3:0] oe_i
);
    logic [3:0] hdq = 4'h0;
    // released lines flip, never hold the last value
    assign line_o = (oe_i & dq_i) | (~oe_i & hdq);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // ********
    // frame tasks, clock still outside frames
    // ********
    task automatic fs();
        cs_n_o = 1'b0;
        #8;
    endtask
    task automatic fe();
        sck_o = 1'b0;
        #7;
        cs_n_o = 1'b1;
        hdq = ~hdq;
        #30;
    endtask
    // single line byte, msb first, reply on line 1
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            hdq = {~hdq[3:1], d[i]};
            #7;
            q[i] = line_o[1];
            sck_o = 1'b1;
            #8;
        end
    endtask
    // one nibble on four lines, driven or released
    task automatic xn(input logic [3:0] d, input logic drv,
                      output logic [3:0] q);
        sck_o = 1'b0;
        hdq = drv ? d : ~hdq;
        #7;
        q = line_o;
        sck_o = 1'b1;
        #8;
    endtask
endmodule

//--- spi_flash_pwrdn_quad_mode_tb.sv
// self-checking bench for the flash command slice
`timescale 1ns/1ns
module spi_flash_pwrdn_quad_mode_tb;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        wp_n = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck;
    logic        cs_n;
    logic [3:0]  line;
    logic [3:0]  dq_out;
    logic [3:0]  dq_oe;
    logic [31:0] r;
    logic        e;
    logic [7:0]  b;
    logic [3:0]  n;
    int          err_count = 0;
    int          total_checks = 0;
    logic [63:0] par = 64'hFF59F600_5CD5A2F7;

    always #20 clk_sys_i = ~clk_sys_i;

    spi_flash_pwrdn_quad_mode dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sck_i(sck),
        .cs_n_i(cs_n), .hold_n_i(1'b1), .wp_n_i(wp_n), .dq_i(line),
        .dq_o(dq_out), .dq_oe_o(dq_oe)
    );
    spi_host_model host (
        .sck_o(sck), .cs_n_o(cs_n), .line_o(line), .dq_i(dq_out),
        .oe_i(dq_oe)
    );
    // ********
    // helpers
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (k >= 40) chk(32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st();
        repeat (8) @(posedge clk_sys_i);
        apb(1'b0, 12'h004, 32'h0, 4'hF);
    endtask
    task automatic sf(input logic [7:0] q[$]);
        host.fs();
        foreach (q[i]) host.xb(q[i], b);
        host.fe();
    endtask
    task automatic qf(input logic op, input logic [7:0] md,
                      input logic [23:0] ad);
        host.fs();
        if (op) host.xb(8'hEB, b);
        for (int i = 5; i >= 0; i--) host.xn(ad[4*i+:4], 1'b1, n);
        host.xn(md[7:4], 1'b1, n);
        host.xn(md[3:0], 1'b1, n);
        repeat (6) host.xn(4'h0, 1'b0, n);
        host.fe();
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ********
    // tests
    // ********
    initial begin
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        st();
        chk(r, 32'h0);
        apb(1'b0, 12'h008, 32'h0, 4'hF);
        chk({r[31:1], e}, 32'h1);
        apb(1'b1, 12'h004, 32'hF, 4'hF);
        st();
        chk(r, 32'h0);
        sf('{8'h05, 8'h00});
        chk(32'(b[0]), 32'h0);
        sf('{8'h01, 8'h00, 8'h02});
        sf('{8'h35, 8'h00});
        chk(32'(b[1]), 32'h1);
        st();
        chk(32'(r[1]), 32'h1);
        sf('{8'h01, 8'h00, 8'h00});
        sf('{8'h35, 8'h00});
        chk(32'(b[1]), 32'h0);
        qf(1'b1, 8'hA5, 24'h0);
        st();
        chk(32'(r[3]), 32'h0);
        sf('{8'h01, 8'h00, 8'h02});
        wp_n <= 1'b0;
        sf('{8'h01, 8'h00, 8'h00});
        sf('{8'h35, 8'h00});
        chk(32'(b[1]), 32'h1);
        wp_n <= 1'b1;
        host.fs();
        for (int i = 0; i < 5; i++) begin
            host.xb(i == 0 ? 8'h5A : i == 3 ? 8'h34 :
                    i == 4 ? 8'hFF : 8'h00, b);
        end
        for (int k = 0; k < 8; k++) begin
            host.xb(8'h00, b);
            chk(32'(b), 32'(par[8*k+:8]));
        end
        host.fe();
        qf(1'b1, 8'hA5, 24'h0);
        st();
        chk(32'(r[3]), 32'h1);
        qf(1'b0, 8'h00, 24'h0);
        st();
        chk(32'(r[3]), 32'h0);
        qf(1'b1, 8'hA5, 24'h0);
        qf(1'b0, 8'hFF, 24'hFFFFFF);
        st();
        chk(32'(r[3]), 32'h0);
        sf('{8'hB9});
        st();
        chk(32'(r[2]), 32'h1);
        host.fs();
        host.xb(8'h05, b);
        host.xb(8'h00, b);
        chk(32'(dq_oe), 32'h0);
        host.fe();
        sf('{8'h01, 8'h00, 8'h00});
        sf('{8'hAB});
        st();
        chk(32'(r[2:0]), 32'h3);
        repeat (75) @(posedge clk_sys_i);
        st();
        chk(32'(r[0]), 32'h0);
        sf('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(32'(b[0]), 32'h0);
        apb(1'b1, 12'h000, 32'h1, 4'hF);
        sf('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(32'(b[0]), 32'h1);
        apb(1'b1, 12'h000, 32'h0, 4'h0);
        st();
        chk(32'(r[0]), 32'h1);
        apb(1'b1, 12'h000, 32'h0, 4'hF);
        st();
        chk(32'(r[0]), 32'h0);
        wrap_up();
    end
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end
endmodule
